// File: bench/msd_regfile_model.sv
// register file model: holds prior result words and takes results back
`timescale 1ns/1ps
module msd_regfile_model
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // preload from the bench
  input wire logic load,
  input wire logic [31:0] load_upper,
  input wire logic [31:0] load_lower,
  // results coming back from the datapath
  input wire logic res_valid,
  input wire logic [31:0] result_upper,
  input wire logic [31:0] result_lower,
  // prior result registers
  output logic [31:0] acc_upper,
  output logic [31:0] acc_lower
);
  // two separate data registers, so upper and lower never alias; the
  // stack pointer and program counter are never modelled as operands
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      acc_upper <= 32'h0;
      acc_lower <= 32'h0;
    end
    else if (load)
    begin
      acc_upper <= load_upper;
      acc_lower <= load_lower;
    end
    else if (res_valid)
    begin
      // every answer is written back unless load is high in the same cycle, one operation at a time
      acc_upper <= result_upper;
      acc_lower <= result_lower;
    end
  end
endmodule

// File: bench/multiply_saturate_datapath_bench.sv
// self-checking bench for the multiply and saturation datapath
`timescale 1ns/1ps
module multiply_saturate_datapath_bench;
  import msd_pkg::*;
  typedef struct {
    msd_op_t op;
    logic [31:0] a, b, el, eh, ah, al;
    logic q;
    logic [5:0] w;
    logic [1:0] s;
  } msd_row_t;
  logic clk, nrst, op_valid, sel_first_top, sel_second_top, load;
  msd_op_t op_code;
  logic [5:0] clamp_width;
  logic [31:0] first_source, second_source, acc_upper, acc_lower;
  logic [31:0] load_upper, load_lower, result_lower, result_upper;
  logic status_write_op, status_write_q, res_valid, res_saturated;
  logic program_status_q, flags_written;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  msd_row_t rows[$];

  msd_datapath dut (.clk(clk), .nrst(nrst), .op_valid(op_valid),
    .op_code(op_code), .sel_first_top(sel_first_top),
    .sel_second_top(sel_second_top), .clamp_width(clamp_width),
    .first_source(first_source), .second_source(second_source),
    .acc_upper(acc_upper), .acc_lower(acc_lower),
    .status_write_op(status_write_op), .status_write_q(status_write_q),
    .res_valid(res_valid), .result_lower(result_lower),
    .result_upper(result_upper), .res_saturated(res_saturated),
    .program_status_q(program_status_q), .flags_written(flags_written));
  msd_regfile_model far (.clk(clk), .nrst(nrst), .load(load),
    .load_upper(load_upper), .load_lower(load_lower),
    .res_valid(res_valid), .result_upper(result_upper),
    .result_lower(result_lower), .acc_upper(acc_upper),
    .acc_lower(acc_lower));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hang is cut short well past the roughly 130 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic r(msd_op_t o, logic [31:0] a, b, el, logic q = 1'h0,
                   logic [5:0] w = 6'h0, logic [1:0] s = 2'h0,
                   logic [31:0] eh = 32'h0, ah = 32'h0, al = 32'h0);
    rows.push_back('{o, a, b, el, eh, ah, al, q, w, s});
  endtask

  // load drops and the flag write takes clr on the same edge the operation is set up
  task automatic present(msd_op_t o, logic [31:0] a, b, logic [5:0] w,
                         logic [1:0] s, logic clr);
    @(negedge clk);
    load = 1'h0;
    status_write_op = clr;
    status_write_q = 1'h0;
    op_valid = 1'h1;
    op_code = o;
    {sel_first_top, sel_second_top} = s;
    clamp_width = w;
    first_source = a;
    second_source = b;
  endtask

  task automatic issue(msd_op_t o, logic [31:0] a, b, logic clr);
    present(o, a, b, 6'h0, 2'h0, clr);
    @(negedge clk);
    op_valid = 1'h0;
    status_write_op = 1'h0;
  endtask

  task automatic stat_write(logic q);
    @(negedge clk);
    status_write_op = 1'h1;
    status_write_q = q;
    @(negedge clk);
    status_write_op = 1'h0;
  endtask

  task automatic chk_out(logic [63:0] res, logic v, logic q);
    chk("res_valid", 64'(v), 64'(res_valid));
    chk("result", res, {result_upper, result_lower});
    chk("flag", 64'(q), 64'(program_status_q));
    chk("flags_written", 64'h0, 64'(flags_written));
  endtask

  initial
  begin
    {nrst, op_valid, sel_first_top, sel_second_top, load} = 5'h0;
    {status_write_op, status_write_q} = 2'h0;
    op_code = MSD_HALFWORD_MUL;
    clamp_width = 6'h0;
    {first_source, second_source, load_upper, load_lower} = 128'h0;
    r(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 32'hFFFFFFF2);
    r(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 32'hF, .s(2'h3));
    r(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 32'hFFFFFFF6,
      .s(2'h1));
    r(MSD_WORD_BY_HALF_MUL, 32'h10000, 32'h8000, 32'hFFFF8000);
    r(MSD_WORD_BY_HALF_MUL, 32'h10000, 32'h7FFF8000, 32'h7FFF,
      .s(2'h1));
    r(MSD_UNSIGNED_LONG_MUL, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1,
      .eh(32'hFFFFFFFE));
    r(MSD_UNSIGNED_LONG_MAC, 32'hFFFFFFFF, 32'h2, 32'h1, .eh(32'h2),
      .al(32'h3));
    r(MSD_UNSIGNED_DOUBLE_ACC_MUL, 32'h2, 32'h3, 32'h4, .eh(32'h2),
      .ah(32'hFFFFFFFF), .al(32'hFFFFFFFF));
    r(MSD_SIGNED_LONG_MUL, 32'hFFFFFFFF, 32'h2, 32'hFFFFFFFE,
      .eh(32'hFFFFFFFF));
    r(MSD_SIGNED_LONG_MAC, 32'hFFFFFFFF, 32'h2, 32'hFFFFFFFD,
      .eh(32'hFFFFFFFF), .ah(32'hFFFFFFFF), .al(32'hFFFFFFFF));
    r(MSD_SIGNED_SAT_SUB, 32'h80000000, 32'h1, 32'h80000000,
      1'h1);
    // clamps saturate the second source; the first must be ignored
    r(MSD_SIGNED_CLAMP, 32'h5, 32'h100, 32'h7F, 1'h1, 6'h8);
    r(MSD_SIGNED_CLAMP, 32'h5, 32'hFFFFFF00, 32'hFFFFFF80, 1'h1,
      6'h8);
    r(MSD_SIGNED_CLAMP, 32'h5, 32'h7F, 32'h7F, 1'h0, 6'h8);
    r(MSD_UNSIGNED_CLAMP, 32'h5, 32'hFFFFFFFF, 32'h0, 1'h1,
      6'h8);
    r(MSD_UNSIGNED_CLAMP, 32'h5, 32'h100, 32'hFF, 1'h1, 6'h8);
    r(MSD_UNSIGNED_CLAMP, 32'h5, 32'hFF, 32'hFF, 1'h0, 6'h8);
    r(MSD_SIGNED_CLAMP_HALVES, 32'h5, 32'h200FE00, 32'hFFFF00, 1'h1,
      6'h9);
    r(MSD_UNSIGNED_CLAMP_HALVES, 32'h5, 32'hFFFF0100, 32'hFF, 1'h1,
      6'h8);
    r(MSD_SIGNED_SAT_ADD_HALVES, 32'h10002, 32'h30004, 32'h40006);
    r(MSD_SIGNED_SAT_SUB_BYTES, 32'h80100005, 32'h1010101,
      32'h800FFF04);
    r(MSD_SIGNED_SAT_ADD_SUB_EXCH, 32'h50009, 32'h20003,
      32'h80007);
    r(MSD_SIGNED_SAT_SUB_ADD_EXCH, 32'h50009, 32'h20003,
      32'h2000B);
    r(MSD_UNSIGNED_SAT_SUB_HALVES, 32'h10005, 32'h20003, 32'h2);
    r(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 32'h15, .s(2'h2));
    r(MSD_SIGNED_SAT_SUB_HALVES, 32'h80000005, 32'h10007,
      32'h8000FFFE);
    r(MSD_SIGNED_SAT_ADD_BYTES, 32'h7F7F0102, 32'h1800304,
      32'h7FFF0406);
    r(MSD_UNSIGNED_SAT_ADD_BYTES, 32'hFF100102, 32'h2200304,
      32'hFF300406);
    r(MSD_UNSIGNED_SAT_SUB_BYTES, 32'h1100504, 32'h2080304,
      32'h80200);
    r(MSD_UNSIGNED_SAT_ADD_HALVES, 32'hFFFF0001, 32'h20003,
      32'hFFFF0004);
    r(MSD_UNSIGNED_SAT_ADD_SUB_EXCH, 32'h50001, 32'h2000A,
      32'hF0000);
    r(MSD_UNSIGNED_SAT_SUB_ADD_EXCH, 32'h10009, 32'h20003,
      32'hB);
    r(MSD_SIGNED_SAT_DOUBLE_ADD, 32'h40000000, 32'h40000000, 32'h7FFFFFFF,
      1'h1);
    r(MSD_SIGNED_SAT_DOUBLE_SUB, 32'h10, 32'h10, 32'hFFFFFFF0);
    repeat (4) @(posedge clk);
    @(negedge clk);
    nrst = 1'h1;
    chk_out(64'h0, 1'h0, 1'h0);
    foreach (rows[i])
    begin
      @(negedge clk);
      {load, status_write_op, status_write_q} = 3'h6;
      {load_upper, load_lower} = {rows[i].ah, rows[i].al};
      present(rows[i].op, rows[i].a, rows[i].b, rows[i].w, rows[i].s, 1'h0);
      @(negedge clk);
      op_valid = 1'h0;
      chk_out({rows[i].eh, rows[i].el}, 1'h1, rows[i].q);
    end
    // preload 3, then accumulate twice through the write-back path
    @(negedge clk);
    load = 1'h1;
    {load_upper, load_lower} = 64'h3;
    issue(MSD_UNSIGNED_LONG_MAC, 32'hFFFFFFFF, 32'h2, 1'h0);
    issue(MSD_UNSIGNED_LONG_MAC, 32'h1, 32'h1, 1'h0);
    chk_out(64'h200000002, 1'h1, 1'h0);
    // back to back: each answer shows for one cycle, then results hold
    present(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 6'h0, 2'h0, 1'h0);
    present(MSD_HALFWORD_MUL, 32'h3FFFE, 32'h50007, 6'h0, 2'h3, 1'h0);
    chk_out(64'hFFFFFFF2, 1'h1, 1'h0);
    @(negedge clk);
    op_valid = 1'h0;
    chk_out(64'hF, 1'h1, 1'h0);
    @(negedge clk);
    chk_out(64'hF, 1'h0, 1'h0);
    // a set in the same cycle as a clear wins
    issue(MSD_SIGNED_SAT_ADD, 32'h7FFFFFFF, 32'h1, 1'h1);
    chk_out(64'h7FFFFFFF, 1'h1, 1'h1);
    chk("saturated", 64'h1, 64'(res_saturated));
    issue(MSD_SIGNED_SAT_ADD, 32'h1, 32'h1, 1'h0);
    chk_out(64'h2, 1'h1, 1'h1);
    chk("saturated", 64'h0, 64'(res_saturated));
    stat_write(1'h0);
    chk("flag", 64'h0, 64'(program_status_q));
    stat_write(1'h1);
    chk("flag", 64'h1, 64'(program_status_q));
    @(negedge clk);
    nrst = 1'h0;
    @(negedge clk);
    nrst = 1'h1;
    chk_out(64'h0, 1'h0, 1'h0);
    @(negedge clk);
    chk_out(64'h0, 1'h0, 1'h0);
    finish_test();
  end
endmodule

// File: rtl/msd_clamp.sv
// generic signed/unsigned n-bit clamp, purely combinational
`timescale 1ns/1ps
module msd_clamp
(
  // request and answer
  msd_clamp_if.unit cl
);
  import msd_pkg::*;
  // ---------------------------------------------------------------
  // bounds
  // ---------------------------------------------------------------
  // width 0 in signed mode is illegal; it is treated as width 1
  wire [5:0] sw = (cl.width == 6'h00) ? 6'h01 : cl.width;
  wire signed [33:0] one = 34'sh1;
  wire signed [33:0] s_max = (one <<< (sw - 6'h01)) - one;
  wire signed [33:0] s_min = -(one <<< (sw - 6'h01));
  wire signed [33:0] u_max = (one <<< cl.width) - one;
  wire signed [33:0] lo = cl.is_signed ? s_min : 34'sh0;
  wire signed [33:0] hi = cl.is_signed ? s_max : u_max;
  wire below = cl.value < lo;
  wire above = cl.value > hi;
  wire signed [33:0] res = below ? lo : (above ? hi : cl.value);
  assign cl.result = res[31:0];
  assign cl.clamped = below | above;
endmodule

// File: rtl/msd_clamp_if.sv
// request and answer wires between the datapath and its clamp unit
`timescale 1ns/1ps
interface msd_clamp_if;
  logic signed [33:0] value;
  logic [5:0] width;
  logic is_signed;
  logic [31:0] result;
  logic clamped;
  modport user (output value, output width, output is_signed,
                input result, input clamped);
  modport unit (input value, input width, input is_signed,
                output result, output clamped);
endinterface

// File: rtl/msd_datapath.sv
// multiply and saturation datapath with sticky saturation flag
// What this block does
// - halfword multiply selects low or high half of each source by selector.
// - halfword multiply is signed 16x16 giving full signed 32-bit product.
// - word-by-half multiply selects low or high signed half of second source.
// - word-by-half multiply keeps upper 32 bits of the 48-bit signed product.
// - unsigned long multiply splits 64-bit product into lower and upper result.
// - unsigned long mac adds product to 64-bit upper:lower accumulator.
// - double-accumulate adds both prior result words to the unsigned product.
// - signed long multiply splits signed 64-bit product into two words.
// - signed long mac adds signed product to signed 64-bit accumulator.
// - long multiplies never touch the condition flags.
// - signed clamp returns -2^(n-1) or 2^(n-1)-1 when out of range.
// - unsigned clamp returns 0 or 2^n-1 when out of range.
// - word ops and clamps set the sticky saturation flag when clamping; lane add/sub does not; otherwise it stays.
// - only an explicit status write or a reset clears the saturation flag.
// - saturating add/sub on words, halves, bytes, exchange, doubling, clamps.
`timescale 1ns/1ps
module msd_datapath
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // operation request
  input wire logic op_valid,
  input wire msd_pkg::msd_op_t op_code,
  input wire logic sel_first_top,
  input wire logic sel_second_top,
  input wire logic [5:0] clamp_width,
  input wire logic [31:0] first_source,
  input wire logic [31:0] second_source,
  input wire logic [31:0] acc_upper,
  input wire logic [31:0] acc_lower,
  // status register access
  input wire logic status_write_op,
  input wire logic status_write_q,
  // results
  output logic res_valid,
  output logic [31:0] result_lower,
  output logic [31:0] result_upper,
  output logic res_saturated,
  output logic program_status_q,
  output logic flags_written
);
  import msd_pkg::*;
  // ---------------------------------------------------------------
  // multiplies
  // ---------------------------------------------------------------
  wire [15:0] fh = sel_first_top ? first_source[31:16]
                                 : first_source[15:0];
  wire [15:0] sh = sel_second_top ? second_source[31:16]
                                  : second_source[15:0];
  wire signed [31:0] hw_prod = $signed(fh) * $signed(sh);
  wire signed [47:0] wh_prod = $signed(first_source) * $signed(sh);
  wire [31:0] wh_top = wh_prod[47:16];
  wire [63:0] u_prod = {32'h0, first_source} * {32'h0, second_source};
  wire signed [63:0] s_prod = $signed(first_source) * $signed(second_source);
  wire [63:0] acc = {acc_upper, acc_lower};
  wire [63:0] u_mac = u_prod + acc;
  wire [63:0] u_dacc = u_prod + {32'h0, acc_upper}
                       + {32'h0, acc_lower};
  wire [63:0] s_mac = s_prod + acc;
  // ---------------------------------------------------------------
  // lane arithmetic
  // ---------------------------------------------------------------
  wire signed [33:0] a32 = {{2{first_source[31]}}, first_source};
  wire signed [33:0] b32 = {{2{second_source[31]}}, second_source};
  // doubling is itself saturated before the add, as a separate clamp
  wire signed [33:0] dbl = b32 <<< 1;
  wire signed [33:0] dbl_c = (dbl > 34'sh7FFFFFFF) ? 34'sh7FFFFFFF :
                             (dbl < -34'sh80000000) ? -34'sh80000000 : dbl;
  wire dbl_sat = (dbl != dbl_c);
  logic signed [33:0] word_val;
  logic word_signed;
  always_comb
  begin
    word_signed = 1'b1;
    case (op_code)
      MSD_SIGNED_SAT_ADD: word_val = a32 + b32;
      MSD_SIGNED_SAT_SUB: word_val = a32 - b32;
      MSD_SIGNED_SAT_DOUBLE_ADD: word_val = a32 + dbl_c;
      MSD_SIGNED_SAT_DOUBLE_SUB: word_val = a32 - dbl_c;
      default: word_val = b32;
    endcase
  end
  msd_clamp_if wcl ();
  assign wcl.value = word_val;
  assign wcl.width = (op_code == MSD_SIGNED_CLAMP ||
                      op_code == MSD_UNSIGNED_CLAMP) ? clamp_width : 6'h20;
  assign wcl.is_signed = (op_code != MSD_UNSIGNED_CLAMP) && word_signed;
  msd_clamp u_wclamp (.cl(wcl));
  // half lanes: 2 lanes, byte lanes: 4 lanes, both saturated per lane
  logic [31:0] half_res;
  logic half_sat;
  logic [31:0] byte_res;
  logic byte_sat;
  logic [1:0] h_sat;
  logic [3:0] b_sat;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_half
      wire signed [17:0] a = {{2{first_source[16*g+15]}},
                              first_source[16*g +: 16]};
      wire [15:0] xb = second_source[16*(1-g) +: 16];
      wire [15:0] nb = second_source[16*g +: 16];
      wire signed [17:0] bx = {{2{xb[15]}}, xb};
      wire signed [17:0] bn = {{2{nb[15]}}, nb};
      wire [17:0] ua = {2'b00, first_source[16*g +: 16]};
      wire [17:0] ubx = {2'b00, xb};
      wire [17:0] ubn = {2'b00, nb};
      logic signed [17:0] v;
      logic uns;
      always_comb
      begin
        uns = 1'b0;
        case (op_code)
          MSD_SIGNED_SAT_ADD_HALVES: v = a + bn;
          MSD_SIGNED_SAT_SUB_HALVES: v = a - bn;
          // exchange: low lane pairs with second's high, high with low
          MSD_SIGNED_SAT_ADD_SUB_EXCH: v = (g == 1) ? a + bx : a - bx;
          MSD_SIGNED_SAT_SUB_ADD_EXCH: v = (g == 1) ? a - bx : a + bx;
          MSD_UNSIGNED_SAT_ADD_HALVES: begin v = $signed(ua + ubn); uns = 1'b1; end
          MSD_UNSIGNED_SAT_SUB_HALVES: begin v = $signed(ua - ubn); uns = 1'b1; end
          MSD_UNSIGNED_SAT_ADD_SUB_EXCH:
          begin
            v = (g == 1) ? $signed(ua + ubx) : $signed(ua - ubx);
            uns = 1'b1;
          end
          MSD_UNSIGNED_SAT_SUB_ADD_EXCH:
          begin
            v = (g == 1) ? $signed(ua - ubx) : $signed(ua + ubx);
            uns = 1'b1;
          end
          MSD_UNSIGNED_CLAMP_HALVES: v = bn;
          default: v = bn;
        endcase
      end
      msd_clamp_if hc ();
      assign hc.value = {{16{v[17]}}, v};
      assign hc.width = (op_code == MSD_SIGNED_CLAMP_HALVES ||
                         op_code == MSD_UNSIGNED_CLAMP_HALVES)
                        ? clamp_width : 6'h10;
      assign hc.is_signed = !(uns || op_code == MSD_UNSIGNED_CLAMP_HALVES);
      msd_clamp u_hclamp (.cl(hc));
      assign half_res[16*g +: 16] = hc.result[15:0];
      assign h_sat[g] = hc.clamped;
    end
    for (g = 0; g < 4; g++)
    begin : g_byte
      wire signed [9:0] a = {{2{first_source[8*g+7]}}, first_source[8*g +: 8]};
      wire signed [9:0] b = {{2{second_source[8*g+7]}},
                             second_source[8*g +: 8]};
      wire [9:0] ua = {2'b00, first_source[8*g +: 8]};
      wire [9:0] ub = {2'b00, second_source[8*g +: 8]};
      logic signed [9:0] v;
      logic uns;
      always_comb
      begin
        uns = 1'b0;
        case (op_code)
          MSD_SIGNED_SAT_ADD_BYTES: v = a + b;
          MSD_SIGNED_SAT_SUB_BYTES: v = a - b;
          MSD_UNSIGNED_SAT_ADD_BYTES: begin v = $signed(ua + ub); uns = 1'b1; end
          MSD_UNSIGNED_SAT_SUB_BYTES: begin v = $signed(ua - ub); uns = 1'b1; end
          default: v = b;
        endcase
      end
      msd_clamp_if bc ();
      assign bc.value = {{24{v[9]}}, v};
      assign bc.width = 6'h08;
      assign bc.is_signed = !uns;
      msd_clamp u_bclamp (.cl(bc));
      assign byte_res[8*g +: 8] = bc.result[7:0];
      assign b_sat[g] = bc.clamped;
    end
  endgenerate
  assign half_sat = |h_sat;
  assign byte_sat = |b_sat;
  // ---------------------------------------------------------------
  // result selection
  // ---------------------------------------------------------------
  logic [31:0] lo_nxt;
  logic [31:0] hi_nxt;
  logic sat_nxt;
  always_comb
  begin
    lo_nxt = 32'h0;
    hi_nxt = 32'h0;
    sat_nxt = 1'b0;
    case (op_code)
      MSD_HALFWORD_MUL: lo_nxt = hw_prod;
      MSD_WORD_BY_HALF_MUL: lo_nxt = wh_top;
      MSD_UNSIGNED_LONG_MUL: {hi_nxt, lo_nxt} = u_prod;
      MSD_UNSIGNED_LONG_MAC: {hi_nxt, lo_nxt} = u_mac;
      MSD_UNSIGNED_DOUBLE_ACC_MUL: {hi_nxt, lo_nxt} = u_dacc;
      MSD_SIGNED_LONG_MUL: {hi_nxt, lo_nxt} = s_prod;
      MSD_SIGNED_LONG_MAC: {hi_nxt, lo_nxt} = s_mac;
      MSD_SIGNED_SAT_ADD, MSD_SIGNED_SAT_SUB,
      MSD_SIGNED_CLAMP, MSD_UNSIGNED_CLAMP:
      begin
        lo_nxt = wcl.result;
        sat_nxt = wcl.clamped;
      end
      MSD_SIGNED_SAT_DOUBLE_ADD, MSD_SIGNED_SAT_DOUBLE_SUB:
      begin
        lo_nxt = wcl.result;
        sat_nxt = wcl.clamped | dbl_sat;
      end
      // lane add/sub leaves the flag alone; lane clamps do report it
      MSD_SIGNED_SAT_ADD_HALVES, MSD_SIGNED_SAT_SUB_HALVES,
      MSD_SIGNED_SAT_ADD_SUB_EXCH, MSD_SIGNED_SAT_SUB_ADD_EXCH,
      MSD_UNSIGNED_SAT_ADD_HALVES, MSD_UNSIGNED_SAT_SUB_HALVES,
      MSD_UNSIGNED_SAT_ADD_SUB_EXCH, MSD_UNSIGNED_SAT_SUB_ADD_EXCH:
        lo_nxt = half_res;
      MSD_SIGNED_CLAMP_HALVES, MSD_UNSIGNED_CLAMP_HALVES:
      begin
        lo_nxt = half_res;
        sat_nxt = half_sat;
      end
      MSD_SIGNED_SAT_ADD_BYTES, MSD_SIGNED_SAT_SUB_BYTES,
      MSD_UNSIGNED_SAT_ADD_BYTES, MSD_UNSIGNED_SAT_SUB_BYTES:
        lo_nxt = byte_res;
      default: lo_nxt = 32'h0;
    endcase
  end
  wire long_op = (op_code == MSD_UNSIGNED_LONG_MUL) ||
                 (op_code == MSD_UNSIGNED_LONG_MAC) ||
                 (op_code == MSD_UNSIGNED_DOUBLE_ACC_MUL) ||
                 (op_code == MSD_SIGNED_LONG_MUL) ||
                 (op_code == MSD_SIGNED_LONG_MAC);
  wire set_q = op_valid && sat_nxt;
  // set wins over an explicit clear in the same cycle
  wire q_nxt = set_q ? 1'b1 :
               (status_write_op ? status_write_q : program_status_q);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      res_valid <= MSD_VALID_RESET;
      result_lower <= 32'h0;
      result_upper <= 32'h0;
      res_saturated <= 1'b0;
      program_status_q <= MSD_Q_RESET;
      flags_written <= 1'b0;
    end
    else
    begin
      res_valid <= op_valid;
      if (op_valid)
      begin
        result_lower <= lo_nxt;
        result_upper <= hi_nxt;
        res_saturated <= sat_nxt;
        flags_written <= 1'b0;
      end
      program_status_q <= q_nxt;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_VALID_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst)
    op_valid |=> res_valid)
    else $error("result valid missing after request");
  AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!nrst)
    !op_valid |=> !res_valid)
    else $error("result valid without request");
  AST_Q_STICKY: assert property (@(posedge clk) disable iff (!nrst)
    program_status_q && !status_write_op |=> program_status_q)
    else $error("saturation flag dropped without write");
  AST_Q_SET: assert property (@(posedge clk) disable iff (!nrst)
    set_q |=> program_status_q && res_saturated)
    else $error("saturation not flagged");
  AST_Q_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !set_q && !status_write_op |=> $stable(program_status_q))
    else $error("saturation flag changed without cause");
  AST_HW_MUL: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op_code == MSD_HALFWORD_MUL |=>
    result_lower == $past({{16{fh[15]}}, fh} * {{16{sh[15]}}, sh}))
    else $error("halfword product wrong");
  AST_UMUL: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op_code == MSD_UNSIGNED_LONG_MUL |=>
    {result_upper, result_lower} ==
    $past({32'h0, first_source} * {32'h0, second_source}))
    else $error("unsigned long product wrong");
  AST_SMAC: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && op_code == MSD_SIGNED_LONG_MAC |=>
    {result_upper, result_lower} ==
    $past({{32{first_source[31]}}, first_source} *
          {{32{second_source[31]}}, second_source} +
          {acc_upper, acc_lower}))
    else $error("signed mac wrong");
  AST_LONG_NO_SAT: assert property (@(posedge clk) disable iff (!nrst)
    op_valid && long_op |=> !res_saturated && !flags_written)
    else $error("long multiply touched flags");
endmodule

// File: rtl/msd_pkg.sv
// constants and types shared by the multiply/saturate datapath
package msd_pkg;
  localparam int MSD_W = 32;
  localparam int MSD_HALF_LO = 0;
  localparam int MSD_HALF_HI = 16;
  localparam int MSD_HALF_W = 16;
  localparam int MSD_BYTE_W = 8;
  localparam logic MSD_Q_RESET = 1'b0;
  localparam logic MSD_VALID_RESET = 1'b0;
  localparam int MSD_LATENCY = 1;
  typedef enum logic [4:0] {
    MSD_HALFWORD_MUL,
    MSD_WORD_BY_HALF_MUL,
    MSD_UNSIGNED_LONG_MUL,
    MSD_UNSIGNED_LONG_MAC,
    MSD_UNSIGNED_DOUBLE_ACC_MUL,
    MSD_SIGNED_LONG_MUL,
    MSD_SIGNED_LONG_MAC,
    MSD_SIGNED_SAT_ADD,
    MSD_SIGNED_SAT_SUB,
    MSD_SIGNED_SAT_ADD_HALVES,
    MSD_SIGNED_SAT_SUB_HALVES,
    MSD_SIGNED_SAT_ADD_BYTES,
    MSD_SIGNED_SAT_SUB_BYTES,
    MSD_SIGNED_SAT_ADD_SUB_EXCH,
    MSD_SIGNED_SAT_SUB_ADD_EXCH,
    MSD_SIGNED_SAT_DOUBLE_ADD,
    MSD_SIGNED_SAT_DOUBLE_SUB,
    MSD_SIGNED_CLAMP,
    MSD_SIGNED_CLAMP_HALVES,
    MSD_UNSIGNED_CLAMP,
    MSD_UNSIGNED_CLAMP_HALVES,
    MSD_UNSIGNED_SAT_ADD_BYTES,
    MSD_UNSIGNED_SAT_ADD_HALVES,
    MSD_UNSIGNED_SAT_SUB_BYTES,
    MSD_UNSIGNED_SAT_SUB_HALVES,
    MSD_UNSIGNED_SAT_ADD_SUB_EXCH,
    MSD_UNSIGNED_SAT_SUB_ADD_EXCH
  } msd_op_t;
endpackage
